// file: include/timer_unit_map.vh
`ifndef TIMER_UNIT_MAP_VH
`define TIMER_UNIT_MAP_VH

// Register offsets, one 16-bit register per word index.
`define REG_COUNT0 4'h0
`define REG_LIMA0 4'h1
`define REG_LIMB0 4'h2
`define REG_CTRL0 4'h3
`define REG_COUNT1 4'h4
`define REG_LIMA1 4'h5
`define REG_LIMB1 4'h6
`define REG_CTRL1 4'h7
`define REG_COUNT2 4'h8
`define REG_LIMA2 4'h9
`define REG_CTRL2 4'ha
`define REG_ADDR_W 4

// Control field positions.
`define CTL_EN 0
`define CTL_ALT 1
`define CTL_EXT 2
`define CTL_PRE 3
`define CTL_CONT 4
`define CTL_WDOG 5
`define CTL_GATE 6
`define CTL_INUSE_B 12
`define CTL_HIT 13
`define CTL_W 7

`define CTRL_RESET 7'h00
`define COUNT_RESET 16'h0000
`define LIMIT_RESET 16'h0000
`define DATA_W 16
`define SLOT_LAST 2'h3
`define SLOT_RESET 2'h0
`define SLOT_T0 2'h0
`define SLOT_T1 2'h1
`define SLOT_T2 2'h2
`define SLOT_STEP 2'h1
`define SYNC_RESET 2'b00
`define RDATA_IDLE 16'h0000

`endif

// file: verilog/timer_channel.v
`timescale 1ns/10ps
`include "timer_unit_map.vh"

module timer_channel #(
    parameter HAS_ALT = 1
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire service_i,
    input wire event_i,
    input wire count_we_i,
    input wire lima_we_i,
    input wire limb_we_i,
    input wire ctrl_we_i,
    input wire [15:0] wdata_i,
    input wire hit_clear_i,
    output reg [15:0] count_o,
    output reg [15:0] lima_o,
    output reg [15:0] limb_o,
    output reg [6:0] ctrl_o,
    output reg use_b_o,
    output reg hit_o,
    output reg tc_o,
    output reg out_o
);

    wire alt_mode = (HAS_ALT != 0) && ctrl_o[`CTL_ALT];
    wire [15:0] active_lim = (alt_mode && use_b_o) ? limb_o : lima_o;
    wire [15:0] count_inc = count_o + 16'h0001;
    wire advance = ctrl_o[`CTL_EN] && service_i && event_i;
    wire reach = advance && (count_inc == active_lim);

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            count_o <= `COUNT_RESET;
            lima_o <= `LIMIT_RESET;
            limb_o <= `LIMIT_RESET;
            ctrl_o <= `CTRL_RESET;
            use_b_o <= 1'b0;
            hit_o <= 1'b0;
            tc_o <= 1'b0;
            out_o <= 1'b1;
        end else begin
            tc_o <= reach;
            if (count_we_i) begin
                count_o <= wdata_i;
            end else if (reach) begin
                count_o <= `COUNT_RESET;
            end else if (advance) begin
                count_o <= count_inc;
            end
            if (lima_we_i) begin
                lima_o <= wdata_i;
            end
            if (limb_we_i && (HAS_ALT != 0)) begin
                limb_o <= wdata_i;
            end
            if (ctrl_we_i) begin
                ctrl_o <= wdata_i[`CTL_W-1:0];
            end else if (reach && !ctrl_o[`CTL_CONT] && !(alt_mode && !use_b_o)) begin
                ctrl_o[`CTL_EN] <= 1'b0;
            end
            // Hardware set wins over a software clear in the same cycle.
            if (reach) begin
                hit_o <= 1'b1;
            end else if (hit_clear_i) begin
                hit_o <= 1'b0;
            end
            if (!alt_mode) begin
                use_b_o <= 1'b0;
            end else if (reach) begin
                use_b_o <= ~use_b_o;
            end
            if (alt_mode) begin
                out_o <= ~(reach ? ~use_b_o : use_b_o);
            end else begin
                out_o <= ~reach;
            end
        end
    end

endmodule

// file: verilog/triple_timer_unit.v
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "timer_unit_map.vh"

// Summary of operation
// - Three independent timers, each with a 16-bit count.
// - Timers zero and one each own an input pin and output pin.
// - Timer one in watchdog mode raises the watchdog interrupt at its limit.
// - Timer two has no pins; serves delays, prescaling or DMA requests.
// - Software may read or overwrite any count at any time.
// - Each selected timer event adds one to the count.
// - Reaching the active limit returns count to zero the same cycle.
// - Timers zero and one alternate primary and secondary limits.
// - Single-limit output pulses low one cycle after the limit.
// - Dual-limit output level shows which limit governs.
// - Timers are serviced in rotation, each once every fourth clock.
// - External inputs at most quarter clock; output may lag six clocks.
// - Eleven 16-bit registers hold counts, limits and control.

module triple_timer_unit (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire timer_zero_input_i,
    input wire timer_one_input_i,
    output wire timer_zero_output_o,
    output wire timer_one_output_o,
    output reg watchdog_irq_o,
    output reg dma_request_o
);

    reg [1:0] slot;
    reg [1:0] sync0;
    reg [1:0] sync1;
    reg in0_prev;
    reg in1_prev;
    reg [1:0] rise_pend;
    reg pre_pend0;
    reg pre_pend1;

    wire [15:0] cnt0, cnt1, cnt2, la0, la1, la2, lb0, lb1, lb2;
    wire [6:0] ct0, ct1, ct2;
    wire ub0, ub1, ub2, hit0, hit1, hit2, tc0, tc1, tc2, out0, out1, out2;
    wire ev0, ev1;
    wire service0, service1, service2;
    wire rise0, rise1;
    wire we_count0, we_lima0, we_limb0, we_ctrl0;
    wire we_count1, we_lima1, we_limb1, we_ctrl1;
    wire we_count2, we_lima2, we_ctrl2;
    wire hit_clear0, hit_clear1, hit_clear2;
    reg [15:0] next_rdata;

    function wr_sel;
        input [3:0] a;
        input [3:0] want;
        input we;
        begin
            wr_sel = we && (a == want);
        end
    endfunction

    function [15:0] ctrl_view;
        input [6:0] c;
        input ub;
        input hit;
        begin
            ctrl_view = 16'h0000;
            ctrl_view[`CTL_W-1:0] = c;
            ctrl_view[`CTL_INUSE_B] = ub;
            ctrl_view[`CTL_HIT] = hit;
        end
    endfunction

    function slot_is;
        input [1:0] s;
        input [1:0] want;
        begin
            slot_is = (s == want);
        end
    endfunction

    // Register write decode, shared by the timers and the watchdog clear.
    assign we_count0 = wr_sel(addr_i, `REG_COUNT0, wr_i);
    assign we_lima0 = wr_sel(addr_i, `REG_LIMA0, wr_i);
    assign we_limb0 = wr_sel(addr_i, `REG_LIMB0, wr_i);
    assign we_ctrl0 = wr_sel(addr_i, `REG_CTRL0, wr_i);
    assign we_count1 = wr_sel(addr_i, `REG_COUNT1, wr_i);
    assign we_lima1 = wr_sel(addr_i, `REG_LIMA1, wr_i);
    assign we_limb1 = wr_sel(addr_i, `REG_LIMB1, wr_i);
    assign we_ctrl1 = wr_sel(addr_i, `REG_CTRL1, wr_i);
    assign we_count2 = wr_sel(addr_i, `REG_COUNT2, wr_i);
    assign we_lima2 = wr_sel(addr_i, `REG_LIMA2, wr_i);
    assign we_ctrl2 = wr_sel(addr_i, `REG_CTRL2, wr_i);

    // Writing a control word with the hit bit low clears that timer's flag.
    assign hit_clear0 = we_ctrl0 && !wdata_i[`CTL_HIT];
    assign hit_clear1 = we_ctrl1 && !wdata_i[`CTL_HIT];
    assign hit_clear2 = we_ctrl2 && !wdata_i[`CTL_HIT];

    // Each timer owns one slot of the four; the last slot is left idle.
    assign service0 = slot_is(slot, `SLOT_T0);
    assign service1 = slot_is(slot, `SLOT_T1);
    assign service2 = slot_is(slot, `SLOT_T2);

    // An edge is judged on the synchronised level only, never on the raw pin.
    assign rise0 = sync0[1] && !in0_prev;
    assign rise1 = sync1[1] && !in1_prev;

    // Rotating service slot; slot 3 is idle so each timer sees one slot in four.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            slot <= `SLOT_RESET;
        end else begin
            slot <= slot + `SLOT_STEP;
        end
    end

    // Pins are brought into the clock domain before any logic looks at them.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            sync0 <= `SYNC_RESET;
            sync1 <= `SYNC_RESET;
            in0_prev <= 1'b0;
            in1_prev <= 1'b0;
        end else begin
            sync0 <= {sync0[0], timer_zero_input_i};
            sync1 <= {sync1[0], timer_one_input_i};
            in0_prev <= sync0[1];
            in1_prev <= sync1[1];
        end
    end

    // Rising edges and prescale terminal counts are held until the timer's slot.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rise_pend <= 2'b00;
            pre_pend0 <= 1'b0;
            pre_pend1 <= 1'b0;
        end else begin
            // A new edge in the timer's own slot wins over the slot's clear.
            if (rise0) begin
                rise_pend[0] <= 1'b1;
            end else if (service0) begin
                rise_pend[0] <= 1'b0;
            end
            if (rise1) begin
                rise_pend[1] <= 1'b1;
            end else if (service1) begin
                rise_pend[1] <= 1'b0;
            end
            if (tc2) begin
                pre_pend0 <= 1'b1;
                pre_pend1 <= 1'b1;
            end else begin
                if (service0) begin
                    pre_pend0 <= 1'b0;
                end
                if (service1) begin
                    pre_pend1 <= 1'b0;
                end
            end
        end
    end

    // Event select: external edge, timer-two prescale, or internal rate; gate level.
    assign ev0 = (ct0[`CTL_EXT] ? rise_pend[0] : (ct0[`CTL_PRE] ? pre_pend0 : 1'b1))
        && (!ct0[`CTL_GATE] || ct0[`CTL_EXT] || sync0[1]);
    assign ev1 = (ct1[`CTL_EXT] ? rise_pend[1] : (ct1[`CTL_PRE] ? pre_pend1 : 1'b1))
        && (!ct1[`CTL_GATE] || ct1[`CTL_EXT] || sync1[1]);

    // Three independent channels, each with its own 16-bit count.
    timer_channel #(.HAS_ALT(1)) u_timer0 (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .service_i(service0),
        .event_i(ev0),
        .count_we_i(we_count0),
        .lima_we_i(we_lima0),
        .limb_we_i(we_limb0),
        .ctrl_we_i(we_ctrl0),
        .wdata_i(wdata_i),
        .hit_clear_i(hit_clear0),
        .count_o(cnt0),
        .lima_o(la0),
        .limb_o(lb0),
        .ctrl_o(ct0),
        .use_b_o(ub0),
        .hit_o(hit0),
        .tc_o(tc0),
        .out_o(out0)
    );

    timer_channel #(.HAS_ALT(1)) u_watchdog_capable_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .service_i(service1),
        .event_i(ev1),
        .count_we_i(we_count1),
        .lima_we_i(we_lima1),
        .limb_we_i(we_limb1),
        .ctrl_we_i(we_ctrl1),
        .wdata_i(wdata_i),
        .hit_clear_i(hit_clear1),
        .count_o(cnt1),
        .lima_o(la1),
        .limb_o(lb1),
        .ctrl_o(ct1),
        .use_b_o(ub1),
        .hit_o(hit1),
        .tc_o(tc1),
        .out_o(out1)
    );

    timer_channel #(.HAS_ALT(0)) u_timer2 (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .service_i(service2),
        .event_i(1'b1),
        .count_we_i(we_count2),
        .lima_we_i(we_lima2),
        .limb_we_i(1'b0),
        .ctrl_we_i(we_ctrl2),
        .wdata_i(wdata_i),
        .hit_clear_i(hit_clear2),
        .count_o(cnt2),
        .lima_o(la2),
        .limb_o(lb2),
        .ctrl_o(ct2),
        .use_b_o(ub2),
        .hit_o(hit2),
        .tc_o(tc2),
        .out_o(out2)
    );

    assign timer_zero_output_o = out0;
    assign timer_one_output_o = out1;

    // The watchdog line is sticky until software writes timer one's control.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            watchdog_irq_o <= 1'b0;
            dma_request_o <= 1'b0;
        end else begin
            dma_request_o <= tc2 && ct2[`CTL_EN];
            if (ct1[`CTL_WDOG] && tc1) begin
                watchdog_irq_o <= 1'b1;
            end else if (we_ctrl1) begin
                watchdog_irq_o <= 1'b0;
            end
        end
    end

    // Read mux; an idle cycle or an unmapped index gives an all-zero word.
    always @* begin
        next_rdata = `RDATA_IDLE;
        if (rd_i) begin
            case (addr_i)
                `REG_COUNT0: next_rdata = cnt0;
                `REG_LIMA0: next_rdata = la0;
                `REG_LIMB0: next_rdata = lb0;
                `REG_CTRL0: next_rdata = ctrl_view(ct0, ub0, hit0);
                `REG_COUNT1: next_rdata = cnt1;
                `REG_LIMA1: next_rdata = la1;
                `REG_LIMB1: next_rdata = lb1;
                `REG_CTRL1: next_rdata = ctrl_view(ct1, ub1, hit1);
                `REG_COUNT2: next_rdata = cnt2;
                `REG_LIMA2: next_rdata = la2;
                `REG_CTRL2: next_rdata = ctrl_view(ct2, ub2, hit2);
                default: next_rdata = `RDATA_IDLE;
            endcase
        end
    end

    // Read port: data stands in the cycle after the strobe only.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= `RDATA_IDLE;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule

// file: test/triple_timer_unit_props.sv
`timescale 1ns/10ps
module triple_timer_unit_props (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire watchdog_irq_o,
    input wire dma_request_o
);
    reg [15:0] lim2;
    // Shadow of the third timer's limit, so count reads can be bounded by it.
    always @(posedge ref_clk_i) begin
        if (reset_i)
            lim2 <= 16'h0000;
        else if (wr_i && addr_i == 4'h9)
            lim2 <= wdata_i;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_wr_rd(a);
        wr_i && addr_i == a ##1 rd_i && addr_i == a;
    endsequence
    property p_rd_idle;
        !rd_i |=> rdata_o == 16'h0000;
    endproperty
    property p_unmapped;
        rd_i && addr_i > 4'ha |=> rdata_o == 16'h0000;
    endproperty
    property p_lima0;
        s_wr_rd(4'h1) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    property p_limb1;
        s_wr_rd(4'h6) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    property p_count2;
        s_wr_rd(4'h8) |=> rdata_o - $past(wdata_i, 2) <= 16'h0001 || rdata_o == 16'h0000;
    endproperty
    property p_below;
        rd_i && addr_i == 4'h8 && lim2 != 16'h0000 |=> rdata_o < $past(lim2);
    endproperty
    property p_dma_gap;
        dma_request_o |=> !dma_request_o [*3];
    endproperty
    property p_wdog_hold;
        watchdog_irq_o && !(wr_i && addr_i == 4'h7) |=> watchdog_irq_o;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_lima0: assert property (p_lima0) else $error("limit readback");
    a_limb1: assert property (p_limb1) else $error("second limit readback");
    a_count2: assert property (p_count2) else $error("count overwrite");
    a_below: assert property (p_below) else $error("count reached limit");
    a_dma_gap: assert property (p_dma_gap) else $error("dma too fast");
    a_wdog_hold: assert property (p_wdog_hold) else $error("watchdog dropped");
endmodule

bind triple_timer_unit triple_timer_unit_props u_props (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .watchdog_irq_o(watchdog_irq_o), .dma_request_o(dma_request_o));

// file: test/pin_pulser.sv
`timescale 1ns/10ps
module pin_pulser (
    input wire ref_clk_i,
    input wire run_i,
    output logic pin_o
);
    logic [1:0] div = 2'h0;
    initial pin_o = 1'b0;
    // Toggling every fourth clock keeps rising edges at most one per eight clocks.
    always @(posedge ref_clk_i) begin
        div <= run_i ? div + 2'h1 : 2'h0;
        if (!run_i)
            pin_o <= 1'b0;
        else if (div == 2'h3)
            pin_o <= ~pin_o;
    end
endmodule

// file: test/triple_timer_unit_test.sv
`timescale 1ns/10ps
module triple_timer_unit_test;
    logic ref_clk_i, reset_i, wr_i, rd_i, run;
    logic [3:0] addr_i;
    logic [15:0] wdata_i, q, seed;
    wire [15:0] rdata_o;
    wire pin0, pin1, out0, out1, irq, dma;
    integer failures, samples_checked, i, n;
    triple_timer_unit dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_zero_input_i(pin0), .timer_one_input_i(pin1), .timer_zero_output_o(out0),
        .timer_one_output_o(out1), .watchdog_irq_o(irq), .dma_request_o(dma));
    pin_pulser src0 (.ref_clk_i(ref_clk_i), .run_i(run), .pin_o(pin0));
    pin_pulser src1 (.ref_clk_i(ref_clk_i), .run_i(run), .pin_o(pin1));
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [15:0] span(input [15:0] lim);
        span = lim * 16'h0004;
    endfunction
    function logic pick(input [1:0] s);
        pick = s == 2'h0 ? out0 : s == 2'h1 ? irq : s == 2'h2 ? dma : out1;
    endfunction
    task check_word(input [15:0] got, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task check_bit(input got, input exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task xfer(input [3:0] a, input [15:0] d, input w, input r);
        @(posedge ref_clk_i);
        wr_i <= w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        rd_i <= r;
        if (r) begin
            @(posedge ref_clk_i);
            rd_i <= 1'b0;
            #1 q = rdata_o;
        end
    endtask
    // Counts falling edges while the chosen output holds a level, bounded.
    task dwell(input [1:0] s, input lvl);
        n = 0;
        while (pick(s) === lvl && n < 200) begin
            @(negedge ref_clk_i);
            n = n + 1;
        end
    endtask
    initial begin
        #400000;
        failures = failures + 1;
        end_of_test;
    end
    initial begin
        failures = 0;
        samples_checked = 0;
        seed = 16'hd1d3;
        reset_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        run = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(negedge ref_clk_i);
        check_bit(out0 & out1 & !irq, 1'b1);
        for (i = 0; i < 16; i = i + 1) begin
            xfer(i[3:0], 16'h0000, 1'b0, 1'b1);
            check_word(q, 16'h0000);
        end
        for (i = 1; i < 16; i = i + 1) begin
            seed = lfsr(seed);
            if (i > 10 || i % 4 == 1 || (i % 4 == 2 && i < 8)) begin
                xfer(i[3:0], seed, 1'b1, 1'b1);
                check_word(q, i > 10 ? 16'h0000 : seed);
            end
        end
        $display("done: registers");
        xfer(4'h1, 16'h0003, 1'b1, 1'b0);
        xfer(4'h0, 16'h0000, 1'b1, 1'b0);
        xfer(4'h3, 16'h0011, 1'b1, 1'b0);
        for (i = 0; i < 6; i = i + 1) begin
            xfer(4'h0, 16'h0000, 1'b0, 1'b1);
            check_bit(q < 16'h0003, 1'b1);
        end
        dwell(2'h0, 1'b1);
        dwell(2'h0, 1'b0);
        check_word(n[15:0], 16'h0001);
        $display("done: single limit");
        xfer(4'h1, 16'h0002, 1'b1, 1'b0);
        xfer(4'h2, 16'h0003, 1'b1, 1'b0);
        xfer(4'h0, 16'h0000, 1'b1, 1'b0);
        xfer(4'h3, 16'h0013, 1'b1, 1'b0);
        dwell(2'h0, 1'b1);
        dwell(2'h0, 1'b0);
        check_word(n[15:0], span(16'h0003));
        dwell(2'h0, 1'b1);
        check_word(n[15:0], span(16'h0002));
        xfer(4'h3, 16'h0000, 1'b1, 1'b0);
        $display("done: dual limit");
        xfer(4'h4, 16'h0000, 1'b1, 1'b0);
        xfer(4'h5, 16'h0000, 1'b1, 1'b0);
        xfer(4'h7, 16'h0015, 1'b1, 1'b0);
        @(posedge ref_clk_i);
        run <= 1'b1;
        repeat (80) @(posedge ref_clk_i);
        run <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        xfer(4'h4, 16'h0000, 1'b0, 1'b1);
        check_word(q, 16'h000a);
        $display("done: external count");
        xfer(4'h4, 16'h0000, 1'b1, 1'b0);
        xfer(4'h5, 16'h0002, 1'b1, 1'b0);
        xfer(4'h7, 16'h0031, 1'b1, 1'b0);
        dwell(2'h1, 1'b0);
        check_bit(irq, 1'b1);
        dwell(2'h3, 1'b1);
        dwell(2'h3, 1'b0);
        check_word(n[15:0], 16'h0001);
        xfer(4'h7, 16'h0000, 1'b1, 1'b0);
        xfer(4'h7, 16'h0000, 1'b1, 1'b0);
        @(negedge ref_clk_i);
        check_bit(irq, 1'b0);
        $display("done: watchdog");
        xfer(4'h9, 16'h0004, 1'b1, 1'b0);
        xfer(4'h8, 16'h0002, 1'b1, 1'b1);
        check_word(q, 16'h0002);
        xfer(4'ha, 16'h0011, 1'b1, 1'b0);
        dwell(2'h2, 1'b0);
        dwell(2'h2, 1'b1);
        check_word(n[15:0], 16'h0001);
        dwell(2'h2, 1'b0);
        check_word(n[15:0], span(16'h0004) - 16'h0001);
        xfer(4'h8, 16'h0001, 1'b1, 1'b1);
        xfer(4'ha, 16'h0000, 1'b1, 1'b0);
        $display("done: prescaler timer");
        end_of_test;
    end
endmodule
